// ==== design/smd_margin_ctrl.sv ====
`timescale 1ns/1ps
// Closed-loop supply margining controller, sixteen channels
module smd_margin_ctrl
    import smd_pkg::*;
#(
    parameter int AVG_CYC    = AVG_CYCLES,
    parameter int SETTLE_CYC = SETTLE_CYCLES
)(
    // Clock, reset, enable
    input  wire logic                     core_clk_in,
    input  wire logic                     rst_in,
    input  wire logic                     ce_in,
    // Command port
    input  wire logic [PAGE_W-1:0]        cmd_page_in,
    input  wire logic [7:0]               cmd_code_in,
    input  wire logic                     cmd_wr_in,
    input  wire logic                     cmd_rd_in,
    input  wire logic [15:0]              cmd_wdata_in,
    output logic      [15:0]              cmd_rdata_out,
    output logic                          cmd_rvalid_out,
    // System state
    input  wire logic [1:0]               margin_req_in,
    input  wire logic                     ignore_faults_in,
    input  wire logic                     all_power_good_in,
    input  wire logic [NUM_CH*3-1:0]      dac_pin_function_config_in,
    input  wire logic [NUM_CH-1:0]        vout_cmd_active_in,
    input  wire logic                     alert_enable_in,
    input  wire logic                     clear_faults_in,
    // Voltage samples, averaged inside in groups of four
    input  wire logic                     smp_valid_in,
    input  wire logic [CH_W-1:0]          smp_ch_in,
    input  wire logic [VOUT_W-1:0]        smp_vout_in,
    input  wire logic [VOUT_W-1:0]        tgt_high_in,
    input  wire logic [VOUT_W-1:0]        tgt_low_in,
    // DAC outputs and status
    output logic      [NUM_CH*CODE_W-1:0] dac_code_out,
    output logic      [NUM_CH-1:0]        dac_oe_out,
    output logic      [NUM_CH-1:0]        margin_fault_out,
    output logic                          status_margin_out,
    output logic                          alert_out,
    output logic                          fault_monitor_en_out
);

    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    logic              slope_r  [NUM_CH];
    logic              open_r   [NUM_CH];
    logic [CODE_W-1:0] cfg_code_r [NUM_CH];
    logic [CODE_W-1:0] code_r   [NUM_CH];
    logic              first_r  [NUM_CH];
    logic              pend_r   [NUM_CH];
    logic              pbelow_r [NUM_CH];
    logic              pabove_r [NUM_CH];
    logic [NUM_CH-1:0] fault_r;
    logic [NUM_CH-1:0] oe_r;
    logic [NUM_CH-1:0] one_step_r;
    logic [NUM_CH*CODE_W-1:0] dac_r;
    logic              status_r;
    logic              alert_r;
    logic              mon_en_r;
    logic [15:0]       rdata_r;
    logic              rvalid_r;
    logic              aim_high_r;
    logic              ign_r;
    logic [31:0]       avg_cnt_r;
    logic [31:0]       settle_cnt_r;
    smd_state_t        state_r;
    smd_state_t        state_nxt;

    smd_cmp_if cmp ();

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------

    // One saturating step; raise means the supply should go up
    function automatic logic [CODE_W-1:0] step_code(input logic [CODE_W-1:0] c,
                                                    input logic raise, input logic slope);
        logic up;
        up = (raise == slope);
        if (up) begin
            return (c == CODE_MAX) ? c : c + 8'h01;
        end else begin
            return (c == CODE_MIN) ? c : c - 8'h01;
        end
    endfunction

    // True when the code is already on the rail it would step toward
    function automatic logic at_rail(input logic [CODE_W-1:0] c, input logic raise, input logic slope);
        return (raise == slope) ? (c == CODE_MAX) : (c == CODE_MIN);
    endfunction

    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------

    // Only pages 0..15 hold margining channels
    wire logic             page_ok_w  = (cmd_page_in < PAGE_W'(NUM_CH));
    wire logic [CH_W-1:0]  page_ch_w  = cmd_page_in[CH_W-1:0];
    wire logic             cfg_hit_w  = page_ok_w && (cmd_code_in == CMD_MARGIN_CFG);
    wire logic             cfg_wr_w   = cfg_hit_w && cmd_wr_in;
    wire logic             req_on_w   = (margin_req_in == MREQ_HIGH) || (margin_req_in == MREQ_LOW);
    wire logic             req_high_w = (margin_req_in == MREQ_HIGH);
    wire logic             avg_tick_w = (avg_cnt_r == 32'(AVG_CYC - 1));
    wire logic             settle_done_w = (settle_cnt_r == 32'(SETTLE_CYC - 1));
    wire logic             start_w    = (state_r == SMD_WAITPG) && all_power_good_in;
    wire logic             active_w   = (state_r == SMD_ACTIVE);

    wire logic [15:0]      cfg_read_w = {slope_r[page_ch_w], open_r[page_ch_w], CFG_ZERO_FIELD,
                                         cfg_code_r[page_ch_w]};

    // margining only where the pin is in DAC use
    logic [NUM_CH-1:0] dac_use_w;
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            dac_use_w[i] = (dac_pin_function_config_in[i*3 +: 3] == PIN_FN_DAC);
        end
    end

    // ---------------------------------------------------------------
    // Controller state
    // ---------------------------------------------------------------

    // Next state of the margining sequence
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SMD_IDLE: begin
                if (req_on_w) begin
                    state_nxt = SMD_WAITPG;
                end
            end
            SMD_WAITPG: begin
                if (!req_on_w) begin
                    state_nxt = SMD_IDLE;
                end else if (all_power_good_in) begin
                    state_nxt = SMD_ACTIVE;
                end
            end
            SMD_ACTIVE: begin
                if (!req_on_w) begin
                    state_nxt = ign_r ? SMD_SETTLE : SMD_IDLE;
                end
            end
            SMD_SETTLE: begin
                if (settle_done_w) begin
                    state_nxt = SMD_IDLE;
                end
            end
            default: begin
                state_nxt = SMD_IDLE;
            end
        endcase
    end

    // State register and the two period counters
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state_r      <= SMD_IDLE;
            avg_cnt_r    <= '0;
            settle_cnt_r <= '0;
            aim_high_r   <= 1'b0;
            ign_r        <= 1'b0;
        end else if (ce_in) begin
            state_r <= state_nxt;
            avg_cnt_r <= (!active_w || avg_tick_w) ? '0 : avg_cnt_r + 32'h1;
            settle_cnt_r <= (state_r == SMD_SETTLE) ? settle_cnt_r + 32'h1 : '0;
            if (state_r != SMD_ACTIVE) begin
                aim_high_r <= req_high_w;
            end
            if (active_w) begin
                ign_r <= ign_r | ignore_faults_in;
            end else if (state_r == SMD_IDLE) begin
                ign_r <= ignore_faults_in;
            end
        end
    end

    // ---------------------------------------------------------------
    // Averager
    // ---------------------------------------------------------------
    assign cmp.aim_high = aim_high_r;

    smd_averager u_avg (
        .core_clk_in  (core_clk_in),
        .rst_in       (rst_in),
        .ce_in        (ce_in),
        .clr_in       (!active_w),
        .smp_valid_in (smp_valid_in),
        .smp_ch_in    (smp_ch_in),
        .smp_vout_in  (smp_vout_in),
        .tgt_high_in  (tgt_high_in),
        .tgt_low_in   (tgt_low_in),
        .cmp          (cmp)
    );

    // ---------------------------------------------------------------
    // Configuration register
    // ---------------------------------------------------------------

    // Per-page writes; unused bits are dropped
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < NUM_CH; i++) begin
                slope_r[i]    <= CFG_RESET[CFG_SLOPE_BIT];
                open_r[i]     <= CFG_RESET[CFG_OPEN_BIT];
                cfg_code_r[i] <= CFG_RESET[CFG_CODE_LSB +: CODE_W];
            end
        end else if (ce_in && cfg_wr_w) begin
            slope_r[page_ch_w]    <= cmd_wdata_in[CFG_SLOPE_BIT];
            open_r[page_ch_w]     <= cmd_wdata_in[CFG_OPEN_BIT];
            cfg_code_r[page_ch_w] <= cmd_wdata_in[CFG_CODE_LSB +: CODE_W];
        end
    end

    // Read answers one cycle later; other codes read zero
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            rdata_r  <= '0;
            rvalid_r <= 1'b0;
        end else if (ce_in) begin
            rvalid_r <= cmd_rd_in;
            if (cmd_rd_in) begin
                rdata_r <= cfg_hit_w ? cfg_read_w : 16'h0000;
            end
        end
    end

    // ---------------------------------------------------------------
    // Per-channel DAC loop
    // ---------------------------------------------------------------

    // Results wait for the period end, so closed-loop codes never move mid-period
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < NUM_CH; i++) begin
                code_r[i]   <= '0;
                first_r[i]  <= 1'b0;
                pend_r[i]   <= 1'b0;
                pbelow_r[i] <= 1'b0;
                pabove_r[i] <= 1'b0;
            end
            fault_r <= '0;
        end else if (ce_in) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (start_w) begin
                    code_r[i]  <= cfg_code_r[i];
                    first_r[i] <= 1'b1;
                    pend_r[i]  <= 1'b0;
                end else if (active_w) begin
                    if (cmp.res_valid && (cmp.res_ch == CH_W'(i))) begin
                        pend_r[i]   <= 1'b1;
                        pbelow_r[i] <= cmp.res_below;
                        pabove_r[i] <= cmp.res_above;
                    end
                    if (open_r[i]) begin
                        code_r[i] <= cfg_code_r[i];
                    end else if (avg_tick_w && pend_r[i] && dac_use_w[i]) begin
                        pend_r[i] <= 1'b0;
                        if (pbelow_r[i] || pabove_r[i]) begin
                            code_r[i]  <= step_code(code_r[i], pbelow_r[i], slope_r[i]);
                            first_r[i] <= 1'b0;
                        end
                    end
                end
            end
            // Fault flags: a new fault wins over a clear in the same cycle
            for (int i = 0; i < NUM_CH; i++) begin
                if (active_w && !open_r[i] && dac_use_w[i] && avg_tick_w && pend_r[i] &&
                    ((!first_r[i] && code_r[i] != cfg_code_r[i] &&
                      (aim_high_r ? pabove_r[i] : pbelow_r[i]) && one_step_r[i]) ||
                     ((pbelow_r[i] || pabove_r[i]) && at_rail(code_r[i], pbelow_r[i], slope_r[i])))) begin
                    fault_r[i] <= 1'b1;
                end else if (clear_faults_in) begin
                    fault_r[i] <= 1'b0;
                end
            end
        end
    end

    // One-step tracker, cleared after the second step is judged
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            one_step_r <= '0;
        end else if (ce_in) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (start_w) begin
                    one_step_r[i] <= 1'b0;
                end else if (active_w && avg_tick_w && pend_r[i]) begin
                    one_step_r[i] <= first_r[i] && (pbelow_r[i] || pabove_r[i]);
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------

    // Drive enables and codes, all registered
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            oe_r      <= '0;
            dac_r     <= '0;
            status_r  <= 1'b0;
            alert_r   <= 1'b0;
            mon_en_r  <= 1'b1;
        end else if (ce_in) begin
            for (int i = 0; i < NUM_CH; i++) begin
                dac_r[i*CODE_W +: CODE_W] <= code_r[i];
                oe_r[i] <= dac_use_w[i] && (active_w || vout_cmd_active_in[i]);
            end
            status_r <= |fault_r;
            alert_r  <= alert_enable_in && (|fault_r);
            mon_en_r <= (state_nxt != SMD_SETTLE) && !(active_w && ign_r);
        end
    end

    assign dac_code_out         = dac_r;
    assign dac_oe_out           = oe_r;
    assign margin_fault_out     = fault_r;
    assign status_margin_out    = status_r;
    assign alert_out            = alert_r;
    assign fault_monitor_en_out = mon_en_r;
    assign cmd_rdata_out        = rdata_r;
    assign cmd_rvalid_out       = rvalid_r;

endmodule

// ==== shared/smd_pkg.sv ====
package smd_pkg;

    // -------------------------------------------------------------
    // Channels and widths
    // -------------------------------------------------------------
    localparam int          NUM_CH        = 16;
    localparam int          CH_W          = 4;
    localparam int          CODE_W        = 8;
    localparam int          VOUT_W        = 16;
    localparam int          PAGE_W        = 5;

    // -------------------------------------------------------------
    // Command code and field layout of margin_configuration
    // -------------------------------------------------------------
    localparam logic [7:0]  CMD_MARGIN_CFG = 8'hDF;
    localparam int          CFG_SLOPE_BIT  = 15;
    localparam int          CFG_OPEN_BIT   = 14;
    localparam int          CFG_CODE_LSB   = 0;
    localparam logic [15:0] CFG_RESET      = 16'h0000;
    localparam logic [5:0]  CFG_ZERO_FIELD = 6'h00;

    // Pin function value meaning plain DAC operation
    localparam logic [2:0]  PIN_FN_DAC     = 3'h0;

    // Code rails
    localparam logic [7:0]  CODE_MIN       = 8'h00;
    localparam logic [7:0]  CODE_MAX       = 8'hFF;

    // Index of the last sample in each four-sample average, and tolerance in percent
    localparam logic [1:0]  LAST_SAMPLE    = 2'h3;
    localparam int          TOL_PCT        = 1;

    // -------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------
    localparam int          CLK_HZ         = 20_000_000;
    localparam int          AVG_PERIOD_MS  = 20;
    localparam int          SETTLE_MS      = 100;
    localparam int          AVG_CYCLES     = AVG_PERIOD_MS * (CLK_HZ / 1000);
    localparam int          SETTLE_CYCLES  = SETTLE_MS * (CLK_HZ / 1000);

    // Margin request encoding from the operation command
    localparam logic [1:0]  MREQ_OFF       = 2'h0;
    localparam logic [1:0]  MREQ_LOW       = 2'h1;
    localparam logic [1:0]  MREQ_HIGH      = 2'h2;

    // Controller states, one-hot
    typedef enum logic [3:0] {
        SMD_IDLE   = 4'b0001,
        SMD_WAITPG = 4'b0010,
        SMD_ACTIVE = 4'b0100,
        SMD_SETTLE = 4'b1000
    } smd_state_t;

endpackage

// ==== shared/smd_cmp_if.sv ====
`timescale 1ns/1ps
// Averaged comparison results passed from the averager to the controller
interface smd_cmp_if;
    import smd_pkg::*;
    logic              aim_high;  // Target in use is the high target
    logic              res_valid; // One-cycle pulse per finished average
    logic [CH_W-1:0]   res_ch;    // Channel of the result
    logic              res_below; // Average below target by more than tolerance
    logic              res_above; // Average above target by more than tolerance

    modport src (input aim_high, output res_valid, res_ch, res_below, res_above);
    modport snk (output aim_high, input res_valid, res_ch, res_below, res_above);
endinterface

// ==== design/smd_averager.sv ====
`timescale 1ns/1ps
// Four-sample averager and tolerance comparator, shared by all channels
module smd_averager
    import smd_pkg::*;
(
    // Clock and control
    input  wire logic              core_clk_in,
    input  wire logic              rst_in,
    input  wire logic              ce_in,
    input  wire logic              clr_in,
    // Sample stream
    input  wire logic              smp_valid_in,
    input  wire logic [CH_W-1:0]   smp_ch_in,
    input  wire logic [VOUT_W-1:0] smp_vout_in,
    input  wire logic [VOUT_W-1:0] tgt_high_in,
    input  wire logic [VOUT_W-1:0] tgt_low_in,
    // Results
    smd_cmp_if.src                 cmp
);

    logic [VOUT_W+1:0] acc_r [NUM_CH];
    logic [1:0]        cnt_r [NUM_CH];
    logic              vld_r;
    logic [CH_W-1:0]   ch_r;
    logic              below_r;
    logic              above_r;

    // Outside the band when a exceeds b and diff * 100 exceeds b * tolerance
    function automatic logic out_of_band(input logic [VOUT_W-1:0] a, input logic [VOUT_W-1:0] b);
        logic [VOUT_W+7:0] diff100;
        logic [VOUT_W+7:0] lim;
        diff100 = (VOUT_W+8)'(a - b) * (VOUT_W+8)'(100);
        lim     = (VOUT_W+8)'(b) * (VOUT_W+8)'(TOL_PCT);
        return (a > b) && (diff100 > lim);
    endfunction

    // Decode of the finished average
    wire logic [VOUT_W+1:0] sum_w  = acc_r[smp_ch_in] + (VOUT_W+2)'(smp_vout_in);
    wire logic [VOUT_W-1:0] avg_w  = sum_w[VOUT_W+1:2];
    wire logic [VOUT_W-1:0] tgt_w  = cmp.aim_high ? tgt_high_in : tgt_low_in;
    wire logic              last_w = (cnt_r[smp_ch_in] == LAST_SAMPLE);

    // Accumulate; restart counts when margining restarts
    always_ff @(posedge core_clk_in) begin
        if (rst_in || (ce_in && clr_in)) begin
            for (int i = 0; i < NUM_CH; i++) begin
                acc_r[i] <= '0;
                cnt_r[i] <= '0;
            end
            vld_r   <= 1'b0;
            ch_r    <= '0;
            below_r <= 1'b0;
            above_r <= 1'b0;
        end else if (ce_in) begin
            vld_r <= 1'b0;
            if (smp_valid_in) begin
                cnt_r[smp_ch_in] <= cnt_r[smp_ch_in] + 2'h1;
                acc_r[smp_ch_in] <= last_w ? '0 : sum_w;
                if (last_w) begin
                    vld_r   <= 1'b1;
                    ch_r    <= smp_ch_in;
                    below_r <= out_of_band(tgt_w, avg_w);
                    above_r <= out_of_band(avg_w, tgt_w);
                end
            end
        end
    end

    assign cmp.res_valid = vld_r;
    assign cmp.res_ch    = ch_r;
    assign cmp.res_below = below_r;
    assign cmp.res_above = above_r;

endmodule

// ==== dv/smd_margin_ctrl_checker.sv ====
`timescale 1ns/1ps
// ----
// Port-level checks of the margining controller
// ----
module smd_chk
    import smd_pkg::*;
(
    // Clock and reset
    input wire logic                     core_clk_in,
    input wire logic                     rst_in,
    // Watched ports
    input wire logic [15:0]              cmd_rdata_out,
    input wire logic                     cmd_rvalid_out,
    input wire logic [1:0]               margin_req_in,
    input wire logic                     all_power_good_in,
    input wire logic [NUM_CH*3-1:0]      dac_pin_function_config_in,
    input wire logic [NUM_CH-1:0]        vout_cmd_active_in,
    input wire logic                     alert_enable_in,
    input wire logic [NUM_CH*CODE_W-1:0] dac_code_out,
    input wire logic [NUM_CH-1:0]        dac_oe_out,
    input wire logic [NUM_CH-1:0]        margin_fault_out,
    input wire logic                     status_margin_out,
    input wire logic                     alert_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    // Outputs are registered, so idle needs a few cycles
    zero_field_a: assert property (cmd_rvalid_out |-> cmd_rdata_out[13:8] == 6'h00)
        else $error("reserved bits set");
    idle_hiz_a: assert property ((margin_req_in == 2'h0 && vout_cmd_active_in == 16'h0000)[*5] |-> dac_oe_out == 16'h0000)
        else $error("DAC driven while idle");
    pg_gate_a: assert property ($rose(dac_oe_out[0]) && !vout_cmd_active_in[0] |-> $past(all_power_good_in, 2))
        else $error("DAC on before power good");
    pin_fn_a: assert property ((dac_pin_function_config_in[5:3] != 3'h0)[*2] |-> !dac_oe_out[1])
        else $error("non-DAC pin driven");
    one_step_a: assert property (dac_oe_out[0] && $past(dac_oe_out[0]) && $changed(dac_code_out[7:0])
        |-> (dac_code_out[7:0] - $past(dac_code_out[7:0]) == 8'h01) || ($past(dac_code_out[7:0]) - dac_code_out[7:0] == 8'h01))
        else $error("step too large");
    step_pace_a: assert property ($changed(dac_code_out[7:0]) && dac_oe_out[0] && margin_req_in != 2'h0
        |=> $stable(dac_code_out[7:0])[*8]) else $error("steps too fast");
    status_a: assert property (status_margin_out == $past(|margin_fault_out))
        else $error("status wrong");
    alert_a: assert property (alert_out == ($past(alert_enable_in) && $past(|margin_fault_out)))
        else $error("alert wrong");
endmodule

// ==== dv/smd_supply_model.sv ====
`timescale 1ns/1ps
// ----
// Supply of channel zero, rising with the DAC code
// ----
module smd_supply_model
    import smd_pkg::*;
(
    // Clock and reset
    input wire logic               core_clk_in,
    input wire logic               rst_in,
    // DAC pin
    input wire logic [CODE_W-1:0]  dac_code_in,
    input wire logic               dac_oe_in,
    // Measurements
    output logic                   smp_valid_out,
    output logic      [CH_W-1:0]   smp_ch_out,
    output logic      [VOUT_W-1:0] smp_vout_out,
    output logic      [VOUT_W-1:0] tgt_high_out,
    output logic      [VOUT_W-1:0] tgt_low_out
);
    logic [VOUT_W-1:0] fb_mv;
    // feedback mV is code * 2048 / 256; floating pin adds none
    assign fb_mv        = dac_oe_in ? 16'(dac_code_in) * 16'h0008 : 16'h0000;
    assign smp_ch_out   = 4'h0;
    assign tgt_high_out = 16'h0758;
    assign tgt_low_out  = 16'h0320;
    // One measurement per clock, output sits at 1000 mV with no margin
    always_ff @(posedge core_clk_in) begin
        smp_valid_out <= !rst_in;
        smp_vout_out  <= 16'h03E8 + fb_mv;
    end
endmodule

// ==== dv/smd_margin_ctrl_tb.sv ====
`timescale 1ns/1ps
module supply_margining_dac_control_tb;
    import smd_pkg::*;
    // ----
    // Stimulus and observed signals
    // ----
    logic        core_clk_in = 1'b0, rst_in = 1'b1, cmd_wr_in = 1'b0, cmd_rd_in = 1'b0, all_power_good_in = 1'b0;
    logic        ignore_faults_in = 1'b0, alert_enable_in = 1'b0, clear_faults_in = 1'b0;
    logic [4:0]  cmd_page_in = 5'h00;
    logic [7:0]  cmd_code_in = 8'hDF;
    logic [15:0] cmd_wdata_in = 16'h0000, vout_cmd_active_in = 16'h0000;
    logic [1:0]  margin_req_in = 2'h0;
    logic [47:0] dac_pin_function_config_in = 48'h0;
    logic [15:0] cmd_rdata_out, dac_oe_out, margin_fault_out, smp_vout_in, tgt_high_in, tgt_low_in;
    logic        cmd_rvalid_out, status_margin_out, alert_out, fault_monitor_en_out, smp_valid_in;
    logic [127:0] dac_code_out;
    logic [3:0]  smp_ch_in;
    int          n_fail = 0, cmp_count = 0;
    typedef struct packed { logic [4:0] p; logic [7:0] c; logic [15:0] d; logic [15:0] e; } smd_row_t;
    smd_row_t rows [5] = '{'{5'h00, 8'hDF, 16'hFFFF, 16'hC0FF}, '{5'h0F, 8'hDF, 16'h3F5A, 16'h005A},
        '{5'h07, 8'hDF, 16'h8123, 16'h8023}, '{5'h10, 8'hDF, 16'h1234, 16'h0000}, '{5'h03, 8'hD0, 16'hABCD, 16'h0000}};

    // Short counts keep the run brief
    smd_margin_ctrl #(.AVG_CYC(40), .SETTLE_CYC(60)) i_dut (.*, .ce_in(1'b1));
    smd_supply_model i_sup (.core_clk_in, .rst_in, .dac_code_in(dac_code_out[7:0]), .dac_oe_in(dac_oe_out[0]),
        .smp_valid_out(smp_valid_in), .smp_ch_out(smp_ch_in), .smp_vout_out(smp_vout_in),
        .tgt_high_out(tgt_high_in), .tgt_low_out(tgt_low_in));

    // Clock of 50 ns
    always #25 core_clk_in = ~core_clk_in;

    // ----
    // Tasks
    // ----
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask
    task automatic results();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Bits for bounded waits: 0 drive enable, 1 monitor enable, 2 fault
    wire logic [2:0] w_bits = {margin_fault_out[0], fault_monitor_en_out, dac_oe_out[0]};
    // A wait that runs out of its bound ends the run
    task automatic wt(input int s, input int b);
        int i = 0;
        while (w_bits[s] !== 1'b1 && i < b) begin
            cyc(1);
            #1 i++;
        end
        if (i >= b) begin
            n_fail++;
            $display("[ERR] wait expected done seen timeout");
            results();
        end
    endtask
    task automatic wr(input logic [4:0] p, input logic [7:0] c, input logic [15:0] d);
        cmd_page_in <= p;
        cmd_code_in <= c;
        cmd_wdata_in <= d;
        cmd_wr_in <= 1'b1;
        cyc(1);
        cmd_wr_in <= 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [4:0] p, input logic [7:0] c, input logic [15:0] e);
        cmd_page_in <= p;
        cmd_code_in <= c;
        cmd_rd_in <= 1'b1;
        cyc(1);
        cmd_rd_in <= 1'b0;
        #1 chk("rvalid", 16'h0001, 16'(cmd_rvalid_out));
        chk("rdata", e, cmd_rdata_out);
        cyc(1);
    endtask

    // ----
    // Main sequence
    // ----
    initial begin
        cyc(2);
        rst_in <= 1'b0;
        #1 chk("monitor after reset", 16'h0001, 16'(fault_monitor_en_out));
        cyc(1);
        foreach (rows[k]) begin
            wr(rows[k].p, rows[k].c, rows[k].d);
            rd(rows[k].p, rows[k].c, rows[k].e);
        end
        // Second reset clears stored configuration
        rst_in <= 1'b1;
        cyc(1);
        rst_in <= 1'b0;
        cyc(1);
        rd(5'h00, 8'hDF, 16'h0000);
        // Closed loop, positive slope, margin high
        wr(5'h00, 8'hDF, 16'h8064);
        wr(5'h01, 8'hDF, 16'h8050);
        dac_pin_function_config_in <= 48'h8;
        margin_req_in <= 2'h2;
        cyc(10);
        #1 chk("oe before pg", 16'h0000, dac_oe_out);
        cyc(1);
        all_power_good_in <= 1'b1;
        #1 wt(0, 8);
        chk("start code", 16'h0064, 16'(dac_code_out[7:0]));
        chk("pin fn oe", 16'h0000, 16'(dac_oe_out[1]));
        chk("last channel oe", 16'h0001, 16'(dac_oe_out[15]));
        cyc(640);
        #1 chk("settled code", 16'h006C, 16'(dac_code_out[7:0]));
        chk("no fault", 16'h0000, margin_fault_out);
        cyc(1);
        margin_req_in <= 2'h0;
        cyc(6);
        #1 chk("oe idle", 16'h0000, dac_oe_out);
        // Voltage command drives DAC pins while idle
        cyc(1);
        vout_cmd_active_in <= 16'h0003;
        cyc(2);
        #1 chk("command oe", 16'h0001, dac_oe_out);
        cyc(1);
        vout_cmd_active_in <= 16'h0000;
        // Open loop with faults ignored, then settle time
        wr(5'h00, 8'hDF, 16'h4030);
        ignore_faults_in <= 1'b1;
        margin_req_in <= 2'h1;
        cyc(200);
        #1 chk("open code", 16'h0030, 16'(dac_code_out[7:0]));
        chk("monitor ignored", 16'h0000, 16'(fault_monitor_en_out));
        cyc(1);
        margin_req_in <= 2'h0;
        ignore_faults_in <= 1'b0;
        cyc(40);
        #1 chk("monitor settling", 16'h0000, 16'(fault_monitor_en_out));
        wt(1, 40);
        // Wrong slope drives code into the rail
        cyc(1);
        wr(5'h00, 8'hDF, 16'h0003);
        alert_enable_in <= 1'b1;
        margin_req_in <= 2'h2;
        #1 wt(2, 400);
        cyc(2);
        #1 chk("status", 16'h0001, 16'(status_margin_out));
        chk("alert", 16'h0001, 16'(alert_out));
        chk("rail code", 16'h0000, 16'(dac_code_out[7:0]));
        cyc(80);
        #1 chk("still margining", 16'h0001, 16'(dac_oe_out[0]));
        chk("saturated code", 16'h0000, 16'(dac_code_out[7:0]));
        cyc(1);
        margin_req_in <= 2'h0;
        cyc(2);
        clear_faults_in <= 1'b1;
        cyc(1);
        clear_faults_in <= 1'b0;
        cyc(3);
        #1 chk("cleared alert", 16'h0000, 16'(alert_out));
        results();
    end
endmodule

bind smd_margin_ctrl smd_chk i_chk (.*);
